//--- design/ee_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "ee_defines.svh"
// Summary of operation
// - 64K bytes, 512 pages of 128
// - Stored words carry parity; read returns stored bits uncorrected
// - Separate lockable 128-byte identification page
// - Bus clock samples and times data
// - Data line open drain only
// - Select bits b3..b1 match chip selects
// - Floating chip select reads as zero
// - Write guard high blocks array writes
// - Write guard low or floating permits writes
// - Guarded: ack select, address; not data
// - Type 1010b array, 1011b id page
// - Select bit zero: 1 read, 0 write
// - Match acks ninth clock; mismatch standby
// - Stop after write starts cycle; bus ignored
module ee_slave
    import ee_pkg::*;
#(
    parameter int ARRAY_BYTES = 65536,
    parameter int PAGE_BYTES = 128,
    parameter int WCYC_CYCLES = `EE_WCYC_CYC,
    parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary identifier value
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_select_pin_high,
    input wire logic chip_select_pin_mid,
    input wire logic chip_select_pin_low,
    input wire logic write_guard,
    output logic busy,
    output logic id_locked
);
    // Geometry is fixed by the flop model; refuse anything else at elaboration
    if (ARRAY_BYTES != (1 << `EE_ADDR_W) || PAGE_BYTES != (1 << `EE_PAGE_BITS)
        || WCYC_CYCLES < 1) begin : g_geometry_bad
        $error("ee_slave: unsupported geometry");
    end

    // Array kept small in flops; parity stands in for correction
    localparam int MEM_W = 16;
    typedef struct packed {
        ee_state_type st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic rw;
        logic idp;
        logic [15:0] addr;
        logic [15:0] ptr;
        logic ack;
        logic busy;
        logic wpend;
        logic lock_req;
        logic [31:0] wcnt;
        logic [7:0] wbuf;
        logic [MEM_W-1:0] wmask;
        logic locked;
        logic sda_o;
        logic oe;
    } ee_state_struct_type;
    ee_state_struct_type s_reg;
    ee_state_struct_type s_next;
    logic [8:0] mem_reg [MEM_W];
    logic [8:0] idm_reg [MEM_W];

    ee_bus_if ev ();
    ee_line_watch u_watch (
        .clock(clock),
        .rstn(rstn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    // Floating pins resolve to zero at the pad; logic sees plain levels
    logic [2:0] cs_code;
    assign cs_code = {chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low};
    logic [3:0] idx;
    assign idx = s_reg.ptr[3:0];
    logic [7:0] rd_byte;
    always_comb begin
        logic [8:0] w;
        w = s_reg.idp ? idm_reg[idx] : mem_reg[idx];
        rd_byte = (s_reg.idp && idx == 4'h0) ? ID_CODE : w[7:0];
        if (^w)
            rd_byte = w[7:0];
    end

    always_comb begin
        s_next = s_reg;
        s_next.wmask = '0;
        if (s_reg.st == EE_WCYCLE) begin
            s_next.wcnt = s_reg.wcnt + 32'h1;
            if (s_reg.wcnt >= 32'(WCYC_CYCLES - 1)) begin
                s_next.st = EE_IDLE;
                s_next.wcnt = '0;
            end
        end else if (ev.start) begin
            s_next.st = EE_SEL;
            s_next.bitn = '0;
            s_next.ack = 1'b0;
            s_next.oe = 1'b0;
        end else if (ev.stop) begin
            s_next.oe = 1'b0;
            s_next.st = (s_reg.wpend) ? EE_WCYCLE : EE_IDLE;
            s_next.wpend = 1'b0;
            s_next.lock_req = 1'b0;
            if (s_reg.lock_req)
                s_next.locked = 1'b1;
        end else if (s_reg.st != EE_IDLE) begin
            if (ev.scl_rise && s_reg.bitn != `EE_CNT_ACK) begin
                s_next.sh = {s_reg.sh[6:0], ev.sda};
                s_next.bitn = s_reg.bitn + 4'h1;
            end else if (ev.scl_rise) begin
                s_next.ack = ~ev.sda;
                s_next.bitn = '0;
            end
            if (ev.scl_fall) begin
                s_next.oe = 1'b0;
                if (s_reg.bitn == `EE_CNT_ACK) begin
                    s_next.oe = 1'b0;
                    unique case (s_reg.st)
                        EE_SEL: begin
                            if (s_reg.sh[7:4] inside {`EE_TYPE_ARRAY, `EE_TYPE_IDPAGE}
                                && s_reg.sh[3:1] == cs_code) begin
                                s_next.oe = 1'b1;
                                s_next.rw = s_reg.sh[0];
                                s_next.idp = s_reg.sh[4];
                                s_next.st = s_reg.sh[0] ? EE_RDATA : EE_ADDR_HI;
                                if (s_reg.sh[0])
                                    s_next.sh = rd_byte;
                            end else begin
                                s_next.st = EE_IDLE;
                            end
                        end
                        EE_ADDR_HI: begin
                            s_next.oe = 1'b1;
                            s_next.addr[15:8] = s_reg.sh;
                            s_next.st = EE_ADDR_LO;
                        end
                        EE_ADDR_LO: begin
                            s_next.oe = 1'b1;
                            s_next.addr[7:0] = s_reg.sh;
                            s_next.ptr = {s_reg.addr[15:8], s_reg.sh};
                            s_next.st = EE_WDATA;
                        end
                        EE_WDATA: begin
                            if (!write_guard && !(s_reg.idp && s_reg.locked)) begin
                                s_next.oe = 1'b1;
                                s_next.wbuf = s_reg.sh;
                                s_next.wmask[idx] = 1'b1;
                                s_next.wpend = 1'b1;
                                if (s_reg.idp && s_reg.addr[`EE_ID_LOCK_BIT])
                                    s_next.lock_req = 1'b1;
                                s_next.ptr[`EE_PAGE_BITS-1:0] = s_reg.ptr[`EE_PAGE_BITS-1:0] + 7'h1;
                            end
                        end
                        EE_RDATA: begin
                            // Master answer not seen yet; decided at next fall
                            s_next.sh = rd_byte;
                        end
                        default: s_next.st = EE_IDLE;
                    endcase
                end else if (s_reg.st == EE_RDATA) begin
                    // Nack ends the read so the line is free for stop
                    if (s_reg.bitn == 4'h0 && !s_reg.ack)
                        s_next.st = EE_IDLE;
                    else
                        s_next.oe = ~s_reg.sh[7];
                end
                if (s_reg.st == EE_RDATA && s_reg.bitn == `EE_CNT_LAST)
                    s_next.ptr = s_reg.ptr + 16'h1;
            end
        end
        s_next.sda_o = 1'b0;
        s_next.busy = (s_next.st == EE_WCYCLE);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < MEM_W; g++) begin : g_mem
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    mem_reg[g] <= '0;
                    idm_reg[g] <= '0;
                end else if (s_reg.wmask[g]) begin
                    if (s_reg.idp)
                        idm_reg[g] <= {^s_reg.wbuf, s_reg.wbuf};
                    else
                        mem_reg[g] <= {^s_reg.wbuf, s_reg.wbuf};
                end
            end
        end
    endgenerate

    assign sda_out = s_reg.sda_o;
    assign sda_oe = s_reg.oe;
    assign busy = s_reg.busy;
    assign id_locked = s_reg.locked;
endmodule // ee_slave
`default_nettype wire

//--- design/ee_defines.svh
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH
`define EE_TYPE_ARRAY 4'ha
`define EE_TYPE_IDPAGE 4'hb
`define EE_ADDR_W 16
`define EE_PAGE_BITS 7
`define EE_ID_LOCK_BIT 10
`define EE_ID_WORDS 7'h08
`define EE_CNT_ACK 4'h8
`define EE_CNT_LAST 4'h7
`define EE_WCYC_MS 4
`define EE_CLK_MHZ 200
`define EE_WCYC_CYC (`EE_WCYC_MS * `EE_CLK_MHZ * 1000)
`endif

//--- design/ee_pkg.sv
package ee_pkg;
    typedef enum logic [2:0] {
        EE_IDLE = 3'b000,
        EE_SEL = 3'b001,
        EE_ADDR_HI = 3'b010,
        EE_ADDR_LO = 3'b011,
        EE_WDATA = 3'b100,
        EE_RDATA = 3'b101,
        EE_WCYCLE = 3'b110
    } ee_state_type;
endpackage

//--- design/ee_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ee_bus_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    modport edge_src (output scl_rise, output scl_fall, output start, output stop, output sda);
    modport edge_dst (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface
`default_nettype wire

//--- design/ee_line_watch.sv
`timescale 1ns/1ps
`default_nettype none
module ee_line_watch (
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    ee_bus_if.edge_src ev
);
    typedef struct packed {
        logic scl;
        logic sda;
    } ee_watch_type;
    ee_watch_type w_reg;
    ee_watch_type w_next;

    always_comb begin
        w_next.scl = scl_in;
        w_next.sda = sda_in;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            w_reg <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            w_reg <= w_next;
        end
    end

    // Both lines compared one sample late so edges line up
    assign ev.scl_rise = scl_in & ~w_reg.scl;
    assign ev.scl_fall = ~scl_in & w_reg.scl;
    assign ev.start = scl_in & w_reg.scl & w_reg.sda & ~sda_in;
    assign ev.stop = scl_in & w_reg.scl & ~w_reg.sda & sda_in;
    assign ev.sda = sda_in;
endmodule // ee_line_watch
`default_nettype wire

//--- verif/ee_slave_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ee_slave_monitor #(
    parameter int WCYC_CYCLES = 20
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic busy,
    input wire logic id_locked
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    int busy_cnt_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_reg <= 0;
        end else begin
            busy_cnt_reg <= busy ? busy_cnt_reg + 1 : 0;
        end
    end
    // Pull held for at least 8 clocks once it begins
    sequence ack_slot;
        sda_oe [*8];
    endsequence
    a_drain_only: assert property (sda_out == 1'b0) else $error("data line driven high");
    a_pull_in_low: assert property ($rose(sda_oe) |-> !scl_in) else $error("pull began in clock high");
    a_free_in_low: assert property ($fell(sda_oe) |-> !scl_in) else $error("release in clock high");
    a_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data line moved in clock high");
    a_ack_hold: assert property ($rose(sda_oe) |-> ack_slot) else $error("pull too short");
    a_busy_quiet: assert property (busy |-> !sda_oe) else $error("bus answered while busy");
    a_busy_stop: assert property ($rose(busy) |-> scl_in && sda_in) else $error("cycle began off stop");
    a_busy_bound: assert property (busy_cnt_reg <= WCYC_CYCLES + 2) else $error("cycle too long");
    a_lock_kept: assert property ($past(id_locked) |-> id_locked) else $error("lock dropped");
endmodule // ee_slave_monitor
`default_nettype wire

//--- verif/ee_mst.sv
`timescale 1ns/1ps
`default_nettype none
module ee_mst (
    input wire logic clock,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Quarter bit of 10 clocks so the slave sees every level
    task automatic q();
        repeat (10) @(posedge clock);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        q();
        scl = 1'b1;
        q();
        r = sda_line;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic start();
        sda_drv = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b0;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b1;
        q();
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule // ee_mst
`default_nettype wire

//--- verif/tb_ee_slave.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb_ee_slave;
    localparam int WCYC = 600;
    localparam logic [7:0] ID_VAL = 8'h5a; // Arbitrary value
    typedef struct {logic [7:0] sel; logic [2:0] cs; logic ack;} ee_row_type;
    ee_row_type rows [9] = '{'{8'ha0, 3'h0, 1'b1}, '{8'hae, 3'h7, 1'b1}, '{8'ha6, 3'h3, 1'b1},
        '{8'hba, 3'h5, 1'b1}, '{8'ha8, 3'h4, 1'b1}, '{8'ha2, 3'h3, 1'b0}, '{8'hc0, 3'h0, 1'b0},
        '{8'ha4, 3'h0, 1'b0}, '{8'h9e, 3'h7, 1'b0}};
    logic clock, rstn, scl, sda_drv, sda_oe, sda_out, busy, id_locked, write_guard, ack;
    logic [2:0] cs;
    logic [3:0] acks;
    logic [7:0] rd;
    wire sda_line;
    int n_fail = 0, tests_run = 0, cyc = 0;
    assign sda_line = sda_drv & ~sda_oe;
    ee_mst i_ee_mst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    ee_slave #(.WCYC_CYCLES(WCYC), .ID_CODE(ID_VAL)) i_ee_slave (.clock(clock), .rstn(rstn), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pin_high(cs[2]),
        .chip_select_pin_mid(cs[1]), .chip_select_pin_low(cs[0]), .write_guard(write_guard),
        .busy(busy), .id_locked(id_locked));
    task automatic results();
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic idle();
        for (int k = 0; k < WCYC + 50 && busy !== 1'b0; k++) @(posedge clock);
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic wr_seq(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] d);
        i_ee_mst.start();
        i_ee_mst.wr_byte(sel, acks[3]);
        i_ee_mst.wr_byte(a[15:8], acks[2]);
        i_ee_mst.wr_byte(a[7:0], acks[1]);
        i_ee_mst.wr_byte(d, acks[0]);
        i_ee_mst.stop();
    endtask
    task automatic rd_seq(input logic [7:0] sel, input logic [15:0] a);
        i_ee_mst.start();
        i_ee_mst.wr_byte(sel, acks[3]);
        i_ee_mst.wr_byte(a[15:8], acks[2]);
        i_ee_mst.wr_byte(a[7:0], acks[1]);
        i_ee_mst.start();
        i_ee_mst.wr_byte(sel | 8'h01, acks[0]);
        i_ee_mst.rd_byte(1'b1, rd);
        i_ee_mst.stop();
        idle();
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Run needs about 19k cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        rstn = 1'b0;
        write_guard = 1'b0;
        cs = 3'h0;
        repeat (16) @(posedge clock);
        #1 rstn = 1'b1;
        `CHK("busy_rst", 1'b0, busy)
        foreach (rows[i]) begin
            cs = rows[i].cs;
            i_ee_mst.start();
            i_ee_mst.wr_byte(rows[i].sel, ack);
            i_ee_mst.stop();
            `CHK("sel_ack", rows[i].ack, ack)
            idle();
        end
        cs = 3'h0;
        wr_seq(8'ha0, 16'h0005, 8'h3c);
        `CHK("wr_acks", 4'hf, acks)
        repeat (3) @(posedge clock);
        `CHK("busy", 1'b1, busy)
        i_ee_mst.start();
        i_ee_mst.wr_byte(8'ha0, ack);
        i_ee_mst.stop();
        `CHK("busy_ack", 1'b0, ack)
        idle();
        rd_seq(8'ha0, 16'h0005);
        `CHK("rd_data", 8'h3c, rd)
        write_guard = 1'b1;
        wr_seq(8'ha0, 16'h0005, 8'hc3);
        `CHK("guard_acks", 4'he, acks)
        idle();
        rd_seq(8'ha0, 16'h0005);
        `CHK("guard_data", 8'h3c, rd)
        write_guard = 1'b0;
        rd_seq(8'hb0, 16'h0000);
        `CHK("id_code", ID_VAL, rd)
        wr_seq(8'hb0, 16'h0400, 8'h00);
        idle();
        `CHK("locked", 1'b1, id_locked)
        wr_seq(8'hb0, 16'h0001, 8'h77);
        `CHK("lock_acks", 4'he, acks)
        idle();
        // Reset in the middle of a write cycle
        wr_seq(8'ha0, 16'h0006, 8'h11);
        rstn = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        `CHK("busy_mid_rst", 1'b0, busy)
        `CHK("lock_mid_rst", 1'b0, id_locked)
        `CHK("oe_mid_rst", 1'b0, sda_oe)
        `CHK("out_mid_rst", 1'b0, sda_out)
        repeat (14) @(posedge clock);
        #1 rstn = 1'b1;
        i_ee_mst.start();
        i_ee_mst.wr_byte(8'ha0, ack);
        i_ee_mst.stop();
        `CHK("sel_after_rst", 1'b1, ack)
        idle();
        results();
    end
endmodule // tb_ee_slave
bind ee_slave ee_slave_monitor #(.WCYC_CYCLES(WCYC_CYCLES)) i_ee_slave_monitor (.clock(clock), .rstn(rstn),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy), .id_locked(id_locked));
`default_nettype wire
